// ===== rtl/asr_readout.v
// Purpose: Serial slave and measurement sequencer of a magnetic angle sensor
// Assumes: Serial clock, select and data are asynchronous; 100 MHz clock
// Notes: Front end and angle math are modelled by a timer and input ports
//   Serial clock period must exceed about six system clock periods
`timescale 1ns/10ps
`default_nettype none
`include "asr_defines.vh"

module asr_readout #(
  parameter MEAS_CYCLES = `ASR_MEAS_CYCLES,
  parameter AGC_TARGET = 12'h800
) (
  input wire clock_in,
  input wire rst_in,
  input wire sclk_in,
  input wire cs_n_in,
  input wire mosi_in,
  input wire wire_mode_select_in,
  input wire [11:0] meas_angle_in,
  input wire [11:0] meas_magnitude_in,
  output wire miso_out,
  output wire miso_oe_n_out,
  output wire done_n_out,
  output wire done_n_oe_n_out,
  output wire active_mode_out,
  output wire reset_cell_off_out,
  output wire [1:0] gain_select_out,
  output wire [5:0] agc_level_out,
  output wire measurement_pending_flag_out,
  output wire frame_error_flag_out
);

  // Sequencer states
  localparam ST_LOW_POWER = 2'h0;
  localparam ST_MEASURE = 2'h1;
  localparam ST_DONE = 2'h2;

  // Even parity over the upper fifteen bits of a frame
  function par15;
    input [14:0] v;
    begin
      par15 = ^v;
    end
  endfunction

  // Frame is usable only with good parity and exact length
  function frame_good;
    input par_ok;
    input len_ok;
    begin
      frame_good = par_ok & len_ok;
    end
  endfunction

  // One saturating gain step toward the target magnitude
  function [5:0] agc_step;
    input [5:0] level;
    input [11:0] mag;
    input [11:0] target;
    begin
      agc_step = level;
      if (mag < target && level != 6'h3f) begin
        agc_step = level + 6'h01;
      end else if (mag > target && level != 6'h00) begin
        agc_step = level - 6'h01;
      end
    end
  endfunction

  // Two-flop synchronisers for pins
  // Select and clock reset to their idle levels, so that no
  // false edge is seen when reset lets go
  reg [1:0] sclk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] mosi_sync_reg;
  reg [1:0] wms_sync_reg;
  reg sclk_prev_reg;
  reg cs_prev_reg;
  always @(posedge clock_in) begin
    if (rst_in) begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
      wms_sync_reg <= 2'h3;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
      cs_sync_reg <= {cs_sync_reg[0], cs_n_in};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
      wms_sync_reg <= {wms_sync_reg[0], wire_mode_select_in};
      sclk_prev_reg <= sclk_sync_reg[1];
      cs_prev_reg <= cs_sync_reg[1];
    end
  end

  wire sclk_s = sclk_sync_reg[1];
  wire cs_s = cs_sync_reg[1];
  wire mosi_s = mosi_sync_reg[1];
  wire wms_s = wms_sync_reg[1];
  // Slave only: edges are derived from the host clock
  wire sclk_rise = sclk_s & ~sclk_prev_reg;
  wire sclk_fall = ~sclk_s & sclk_prev_reg;
  wire cs_fall = ~cs_s & cs_prev_reg;
  wire cs_rise = cs_s & ~cs_prev_reg;

  // Serial shifter and frame counter
  reg [15:0] rx_reg;
  reg [15:0] tx_reg;
  reg [4:0] bit_cnt_reg;
  // Write transaction bookkeeping and reply
  reg [15:0] reply_reg;
  reg write_pend_reg;
  reg [13:0] write_addr_reg;
  reg frame_error_reg;
  reg parity_err_reg;
  // Settings and measurement results
  reg [7:0] pwr_cell_reg;
  reg [1:0] gain_reg;
  reg [5:0] agc_reg;
  reg [11:0] angle_reg;
  // Sequencer
  reg pending_reg;
  reg done_n_reg;
  reg [1:0] state_reg;
  reg [31:0] meas_cnt_reg;
  reg start_meas_reg;

  // Command frame: bit 15 read, bits 14:1 address, bit 0 parity;
  // reply frame: bits 15:2 data, bit 1 error, bit 0 parity;
  // write data frame: bits 15:2 data, bit 1 unused, bit 0 parity
  // Decoded fields of the frame just closed
  wire rx_read = rx_reg[15];
  wire [13:0] rx_addr = rx_reg[14:1];
  wire [13:0] wr_data = rx_reg[15:2]; // Data field of a write frame
  wire rx_par_ok = (par15(rx_reg[15:1]) == rx_reg[0]);
  wire rx_len_ok = (bit_cnt_reg == 5'h10);
  wire rx_frame_ok = frame_good(rx_par_ok, rx_len_ok);

  // Register read mux for the next reply
  reg [13:0] rd_data;
  always @* begin
    case (rx_addr)
      `ASR_ADDR_ANGLE: rd_data = {2'h0, angle_reg};
      `ASR_ADDR_PWR_CELL: rd_data = {6'h00, pwr_cell_reg};
      `ASR_ADDR_SYS_CFG: rd_data = {gain_reg, 12'h000};
      `ASR_ADDR_AGC: rd_data = {8'h00, agc_reg};
      `ASR_ADDR_ERR_STAT: rd_data = {11'h000, pending_reg, 1'b0,
        parity_err_reg};
      default: rd_data = 14'h0000;
    endcase
  end

  // Reply frame: data, error flag, even parity
  wire reply_err = frame_error_reg | ~rx_frame_ok;
  wire [14:0] reply_up = {rd_data, reply_err};
  wire [15:0] reply_word = {reply_up, par15(reply_up)};
  // Fetch is a read of the angle address with a clean frame;
  // the data frame of a write is never taken as a fetch
  wire fetch_cmd = rx_read & (rx_addr == `ASR_ADDR_ANGLE) &
    rx_frame_ok & ~write_pend_reg;

  // Shifting: sample on falling edge, drive on rising edge, MSB first
  always @(posedge clock_in) begin
    if (rst_in) begin
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end else if (cs_fall) begin
      tx_reg <= reply_reg; // Reply prepared at the previous frame end
      bit_cnt_reg <= 5'h00;
    end else if (~cs_s) begin
      if (sclk_fall) begin
        rx_reg <= {rx_reg[14:0], mosi_s};
        // Counter saturates so an overlong frame never looks valid
        if (bit_cnt_reg != 5'h1f) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
      if (sclk_rise && bit_cnt_reg != 5'h00) begin
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // Frame end: execute command, latch reply, update settings
  always @(posedge clock_in) begin
    if (rst_in) begin
      reply_reg <= 16'h0000;
      write_pend_reg <= 1'b0;
      write_addr_reg <= 14'h0000;
      frame_error_reg <= 1'b0;
      parity_err_reg <= 1'b0;
      pwr_cell_reg <= `ASR_PWR_CELL_RST;
      gain_reg <= `ASR_GAIN_RST;
      start_meas_reg <= 1'b0;
    end else begin
      // Start request is a one-cycle pulse
      start_meas_reg <= 1'b0;
      if (cs_rise) begin
        reply_reg <= reply_word;
        frame_error_reg <= ~rx_frame_ok;
        if (~rx_frame_ok) begin
          parity_err_reg <= 1'b1;
          write_pend_reg <= 1'b0;
        end else if (write_pend_reg) begin
          // Data frame of a write transaction
          write_pend_reg <= 1'b0;
          if (write_addr_reg == `ASR_ADDR_PWR_CELL) begin
            pwr_cell_reg <= wr_data[7:0];
          end
          if (write_addr_reg == `ASR_ADDR_SYS_CFG) begin
            gain_reg <= wr_data[13:12];
          end
          if (write_addr_reg == `ASR_ADDR_SOFT_RST ||
              write_addr_reg == `ASR_ADDR_MSTR_RST) begin
            gain_reg <= `ASR_GAIN_RST;
            pwr_cell_reg <= `ASR_PWR_CELL_RST;
            parity_err_reg <= 1'b0;
          end
        end else if (!rx_read) begin
          write_pend_reg <= (rx_addr != `ASR_ADDR_NOP);
          write_addr_reg <= rx_addr;
        end else if (rx_addr == `ASR_ADDR_CLR_ERR) begin
          parity_err_reg <= 1'b0;
          frame_error_reg <= 1'b0;
        end
        // Host keeps off while busy, so no queueing here
        if (fetch_cmd && state_reg == ST_LOW_POWER) begin
          start_meas_reg <= 1'b1;
        end
      end
    end
  end

  // Next-state logic of the measurement sequencer
  reg [1:0] state_next;
  reg [31:0] meas_cnt_next;
  reg pending_next;
  reg done_n_next;
  reg meas_end;
  always @* begin
    // Hold by default; only the cases below move
    state_next = state_reg;
    meas_cnt_next = meas_cnt_reg;
    pending_next = pending_reg;
    done_n_next = done_n_reg;
    meas_end = 1'b0;
    case (state_reg)
      ST_LOW_POWER: begin
        if (start_meas_reg) begin
          state_next = ST_MEASURE;
          done_n_next = 1'b1;
          pending_next = 1'b1;
          meas_cnt_next = 32'h0;
        end
      end
      ST_MEASURE: begin
        if (meas_cnt_reg >= MEAS_CYCLES - 1) begin
          state_next = ST_DONE;
          done_n_next = 1'b0;
          pending_next = 1'b0;
          meas_end = 1'b1;
        end else begin
          meas_cnt_next = meas_cnt_reg + 32'h1;
        end
      end
      ST_DONE: begin
        state_next = ST_LOW_POWER;
      end
      default: state_next = ST_LOW_POWER;
    endcase
  end

  // Sequencer registers; angle captured as the measurement ends
  always @(posedge clock_in) begin
    if (rst_in) begin
      state_reg <= ST_LOW_POWER;
      meas_cnt_reg <= 32'h0;
      pending_reg <= 1'b0;
      done_n_reg <= 1'b1;
      angle_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      meas_cnt_reg <= meas_cnt_next;
      pending_reg <= pending_next;
      done_n_reg <= done_n_next;
      if (meas_end) begin
        angle_reg <= meas_angle_in;
      end
    end
  end

  // Gain loop nudges amplification toward a target magnitude
  always @(posedge clock_in) begin
    if (rst_in) begin
      agc_reg <= `ASR_AGC_RST;
    end else if (meas_end) begin
      agc_reg <= agc_step(agc_reg, meas_magnitude_in, AGC_TARGET);
    end
  end

  // 4-wire releases the reply pin while deselected; 3-wire keeps it
  // driven from the second clock after reset, as the mode synchroniser resets to 4-wire
  assign miso_out = tx_reg[15];
  assign miso_oe_n_out = cs_s & wms_s;
  // Completion pin is always driven
  assign done_n_out = done_n_reg;
  assign done_n_oe_n_out = 1'b0;
  assign active_mode_out = (state_reg != ST_LOW_POWER);
  // Reset cell is only switched off while the device sleeps
  assign reset_cell_off_out = (pwr_cell_reg == `ASR_PWR_CELL_OFF) &
    (state_reg == ST_LOW_POWER);
  assign gain_select_out = gain_reg;
  assign agc_level_out = agc_reg;
  assign measurement_pending_flag_out = pending_reg;
  assign frame_error_flag_out = frame_error_reg;

endmodule
`default_nettype wire

// ===== inc/asr_defines.vh
// Purpose: Constants for the angle sensor serial readout block
// Assumes: 100 MHz system clock
// Notes: Addresses are 14-bit register addresses carried in bits 14:1
`ifndef ASR_DEFINES_VH
`define ASR_DEFINES_VH
`define ASR_FRAME_BITS 16
`define ASR_ADDR_ANGLE 14'h3fff
`define ASR_ADDR_PWR_CELL 14'h3f22
`define ASR_ADDR_SYS_CFG 14'h3f20
`define ASR_ADDR_AGC 14'h3ff8
`define ASR_ADDR_ERR_STAT 14'h335a
`define ASR_ADDR_CLR_ERR 14'h3380
`define ASR_ADDR_SOFT_RST 14'h3c00
`define ASR_ADDR_MSTR_RST 14'h33a5
`define ASR_ADDR_NOP 14'h0000
`define ASR_PWR_CELL_RST 8'h00
`define ASR_PWR_CELL_OFF 8'h5a
`define ASR_AGC_RST 6'h20
`define ASR_GAIN_RST 2'h0
`define ASR_CLK_MHZ 100
`define ASR_MEAS_TIME_NS 20000
`define ASR_MEAS_CYCLES ((`ASR_MEAS_TIME_NS * `ASR_CLK_MHZ) / 1000)
`endif

// ===== dv/asr_readout_props.sv
// Purpose: Port assertions for the angle sensor readout block
// Assumes: MEAS_CYCLES equals the value of the bound instance
// Notes: Select idle time is counted to judge frame-free stretches
`timescale 1ns/10ps
`default_nettype none
module asr_readout_props #(
  parameter MEAS_CYCLES = 20
) (
  input wire clock_in,
  input wire rst_in,
  input wire cs_n_in,
  input wire wire_mode_select_in,
  input wire miso_oe_n_out,
  input wire done_n_out,
  input wire active_mode_out,
  input wire [1:0] gain_select_out,
  input wire measurement_pending_flag_out,
  input wire frame_error_flag_out
);
  localparam int LO = MEAS_CYCLES - 2;
  localparam int HI = MEAS_CYCLES + 4;
  logic [4:0] cs_hi_cnt;
  logic [15:0] meas_cnt;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Idle time on select and length of the busy phase
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cs_hi_cnt <= 5'h00;
      meas_cnt <= 16'h0000;
    end else begin
      cs_hi_cnt <= cs_n_in ? cs_hi_cnt + {4'h0, ~&cs_hi_cnt} : 5'h00;
      meas_cnt <= measurement_pending_flag_out ? meas_cnt + 16'h0001 : 16'h0;
    end
  end
  // Wake means busy line and active mode together
  sequence s_wake;
    ##[0:2] (done_n_out && active_mode_out);
  endsequence
  a_fetch_wake: assert property (
    $rose(measurement_pending_flag_out) |-> s_wake) else $error("no wake");
  a_done_clears: assert property (
    $fell(done_n_out) |-> ##[0:1] !measurement_pending_flag_out)
    else $error("pending flag kept after done");
  a_sleep_after: assert property (
    $fell(done_n_out) |-> ##[0:2] !active_mode_out)
    else $error("active mode kept after done");
  a_meas_len: assert property (
    $fell(measurement_pending_flag_out) |-> meas_cnt >= LO && meas_cnt <= HI)
    else $error("measurement length off");
  a_meas_bound: assert property (
    measurement_pending_flag_out |-> meas_cnt <= HI)
    else $error("measurement overruns");
  a_no_rerun: assert property (
    cs_hi_cnt > 12 && !done_n_out |=> !done_n_out)
    else $error("measurement without a frame");
  a_cfg_hold: assert property (
    cs_hi_cnt > 12 |=> $stable(gain_select_out))
    else $error("gain changed without a frame");
  a_err_hold: assert property (
    cs_hi_cnt > 12 |=> $stable(frame_error_flag_out))
    else $error("error flag changed without a frame");
  a_miso_idle: assert property (
    cs_hi_cnt > 4 && wire_mode_select_in && $past(wire_mode_select_in, 3)
    |-> miso_oe_n_out) else $error("reply driven while idle");
  a_chain_drive: assert property (
    !wire_mode_select_in && !$past(wire_mode_select_in, 3)
    |-> !miso_oe_n_out) else $error("reply pin released in 3-wire mode");
endmodule
bind asr_readout asr_readout_props #(.MEAS_CYCLES(MEAS_CYCLES)) u_props (.*);
`default_nettype wire

// ===== dv/asr_host_model.sv
// Purpose: Host controller acting as mode 1 serial master
// Assumes: 125 ns serial clock, held low between frames
// Notes: Parity is formed by the caller, so bad frames can be sent
`timescale 1ns/10ps
`default_nettype none
module asr_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  // Idle link: select high, clock low
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // One frame; data changes on rise, both sides sample on fall
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_out = 1'b0;
    #62.5;
    for (int i = 15; i >= 0; i--) begin
      sclk_out = 1'b1;
      mosi_out = tx[i];
      #62.5;
      sclk_out = 1'b0;
      rx[i] = miso_in;
      #62.5;
    end
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out; // Released line keeps no stale bit
    #250;
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the angle sensor readout block
// Assumes: Short measurement time of 20 cycles
// Notes: Angle rows first, then gain, reset cell and parity cases
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock_in, rst_in, wms;
  logic [11:0] angle, mag;
  logic [15:0] rx;
  wire sclk, cs_n, mosi, miso, miso_oe_n, done_n, act, cell_off, pend, ef;
  wire [1:0] gain;
  wire [5:0] agc;
  wire miso_line = miso_oe_n ? 1'b1 : miso; // Pull-up on released line
  int err_count, samples_checked, cyc;
  int wake_count, w;
  always @(posedge pend) wake_count++; // Counts measurement starts
  logic [25:0] rows [4] = '{{12'h000, 14'h0000}, {12'hfff, 14'h0fff},
                            {12'h5a5, 14'h05a5}, {12'h001, 14'h0001}};
  asr_readout #(.MEAS_CYCLES(20)) dut (.clock_in(clock_in), .rst_in(rst_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
    .wire_mode_select_in(wms), .meas_angle_in(angle),
    .meas_magnitude_in(mag), .miso_out(miso), .miso_oe_n_out(miso_oe_n),
    .done_n_out(done_n), .done_n_oe_n_out(), .active_mode_out(act),
    .reset_cell_off_out(cell_off), .gain_select_out(gain),
    .agc_level_out(agc), .measurement_pending_flag_out(pend),
    .frame_error_flag_out(ef));
  asr_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso_line));
  task automatic chk(input string name, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [15:0] fr(input logic [14:0] u);
    return {u, ^u};
  endfunction
  task automatic xf(input logic [15:0] tx);
    host.xfer(tx, rx);
  endtask
  // Bounded wait for the completion line
  task automatic wait_done;
    int n;
    n = 0;
    while (done_n !== 1'b0 && n < 300) begin
      @(negedge clock_in);
      n++;
    end
    repeat (2) @(negedge clock_in); // Let the sleep step settle
    chk("done_n", {15'h0, done_n}, 16'h0);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // Hang guard, about three times the roughly 6800 cycles needed
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    rst_in = 1'b1;
    wms = 1'b1;
    angle = 12'h000;
    mag = 12'h800;
    repeat (10) @(negedge clock_in);
    rst_in = 1'b0;
    chk("done_n", {15'h0, done_n}, 16'h0001);
    chk("agc", {10'h0, agc}, 16'h0020);
    chk("gain", {14'h0, gain}, 16'h0000);
    chk("oe_n", {15'h0, miso_oe_n}, 16'h0001);
    repeat (5) @(negedge clock_in);
    // Fetch, fetch again to sample, then any read returns the angle
    foreach (rows[i]) begin
      @(negedge clock_in);
      angle = rows[i][25:14];
      w = wake_count;
      xf(fr({1'b1, 14'h3fff}));
      wait_done();
      chk("wakes", 16'(wake_count - w), 16'h0001);
      chk("pend", {15'h0, pend}, 16'h0);
      chk("active", {15'h0, act}, 16'h0);
      xf(fr({1'b1, 14'h3fff}));
      wait_done();
      xf(fr({1'b1, 14'h335a}));
      chk("reply", {1'b0, rx[15:1]}, {1'b0, rows[i][13:0], 1'b0});
      chk("rx_par", {15'h0, ^rx}, 16'h0);
    end
    // Every gain code written through a command and data frame
    for (int g = 0; g < 4; g++) begin
      xf(fr({1'b0, 14'h3f20}));
      xf(fr({g[1:0], 13'h0000}));
      chk("gain", {14'h0, gain}, g[15:0]);
    end
    xf(fr({1'b0, 14'h3f22}));
    xf(fr({6'h00, 8'h5a, 1'b0}));
    chk("cell_off", {15'h0, cell_off}, 16'h0001);
    xf(fr({1'b0, 14'h3f22}));
    xf(fr(15'h0000));
    chk("cell_off", {15'h0, cell_off}, 16'h0000);
    // Fetch with wrong parity must not run and must be flagged
    w = wake_count;
    xf(fr({1'b1, 14'h3fff}) ^ 16'h0001);
    chk("done_n", {15'h0, done_n}, 16'h0000);
    chk("bad_wakes", 16'(wake_count - w), 16'h0000);
    chk("ef_pin", {15'h0, ef}, 16'h0001);
    xf(fr({1'b1, 14'h3380}));
    chk("ef_bit", {15'h0, rx[1]}, 16'h0001);
    // Mid-run reset returns settings and completion line to defaults
    @(negedge clock_in);
    rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    rst_in = 1'b0;
    mag = 12'h100;
    chk("gain_rst", {14'h0, gain}, 16'h0000);
    chk("done_rst", {15'h0, done_n}, 16'h0001);
    chk("agc_rst", {10'h0, agc}, 16'h0020);
    repeat (5) @(negedge clock_in);
    // Fixed guard wait instead of polling the completion line
    w = wake_count;
    xf(fr({1'b1, 14'h3fff}));
    repeat (40) @(negedge clock_in);
    chk("guard_done", {15'h0, done_n}, 16'h0000);
    chk("guard_wakes", 16'(wake_count - w), 16'h0001);
    chk("agc_up", {10'h0, agc}, 16'h0021);
    // 3-wire mode keeps the reply pin driven, frames still work
    wms = 1'b0;
    repeat (4) @(negedge clock_in);
    chk("oe_3w", {15'h0, miso_oe_n}, 16'h0000);
    xf(fr({1'b1, 14'h3ff8}));
    xf(fr({1'b1, 14'h0000}));
    chk("agc_3w", {2'h0, rx[15:2]}, 16'h0021);
    chk("par_3w", {15'h0, ^rx}, 16'h0);
    @(negedge clock_in);
    wms = 1'b1;
    repeat (4) @(negedge clock_in);
    chk("oe_4w", {15'h0, miso_oe_n}, 16'h0001);
    complete_run();
  end
endmodule
`default_nettype wire
